//--- design/ext_bus_regs.vh
`ifndef EXT_BUS_REGS_VH
`define EXT_BUS_REGS_VH
// bus state codes
`define ST_IDLE      3'h0
`define ST_IDLE_INS  3'h1
`define ST_ACCESS    3'h2
`define ST_RELEASED  3'h3
// access length in states, one basic access
`define ACCESS_STATES 2'h2
// module-stop values that break bus release in sleep
`define MSTOP_ALL     16'hFFFF
`define MSTOP_ALT     16'hEFFF
// reset values of idle enables
`define IDLE_EN_RESET 1'h1
// master identities
`define MST_NONE 2'h0
`define MST_CPU  2'h1
`define MST_XFER 2'h2
`endif

//--- design/master_arbiter.v
`timescale 1ns/100ps
`default_nettype none
`include "ext_bus_regs.vh"
module master_arbiter
(
   // clock and reset
   input  wire       ref_clk_i,
   input  wire       reset_n_i,
   // requests
   input  wire       cpu_req_i,
   input  wire       cpu_sleep_i,
   input  wire       xfer_req_i,
   input  wire       xfer_op_busy_i,
   input  wire       cpu_locked_i,
   input  wire       cycle_boundary_i,
   // grants
   output reg  [1:0] owner_o
);
   // ===========================================
   // owner selection
   reg  [1:0] next_owner;
   wire       can_switch;
   // cpu yields at a cycle boundary outside split accesses, or at once when asleep
   assign can_switch = (cycle_boundary_i && !cpu_locked_i) || cpu_sleep_i; // R14 R15
   always @*
   begin
      next_owner = owner_o;
      case (owner_o)
         `MST_NONE:
         begin
            if (xfer_req_i)
               next_owner = `MST_XFER; // R13
            else if (cpu_req_i)
               next_owner = `MST_CPU;
         end
         `MST_CPU:
         begin
            if (xfer_req_i && can_switch)
               next_owner = `MST_XFER; // R14
            else if (!cpu_req_i && can_switch)
               next_owner = `MST_NONE;
         end
         `MST_XFER:
         begin
            // the controller never drops the bus mid operation
            if (!xfer_req_i && !xfer_op_busy_i) // R17
               next_owner = cpu_req_i ? `MST_CPU : `MST_NONE;
         end
         default:
            next_owner = `MST_NONE;
      endcase
   end
   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         owner_o <= `MST_NONE;
      else
         owner_o <= next_owner;
   end
endmodule // master_arbiter
`default_nettype wire

//--- design/ext_bus_idle_release_arbiter.v
// Summary of operation
// R1: with read-read enable set, reads in different areas get an idle state first.
// R2: with write-after-read enable set, a write right after a read gets idle first.
// R3: every inserted idle state is exactly one clock, only between bus cycles.
// R4: both idle enables come out of reset set.
// R5: in idle, address shows next cycle, data floats, strobes and selects high.
// R6: bus release only in expanded mode with release enable set, else ignored.
// R7: the outside master holds its request low as long as it needs the bus.
// R8: on sampled request, acknowledge goes low and all bus outputs float.
// R9: while released, internal external accesses wait for the request to drop.
// R10: with request-out enable set, a waiting access drives the drop request low.
// R11: when the request returns high, acknowledge goes high and driving resumes.
// R12: release wins over a simultaneous internal external access.
// R13: the highest priority requesting master is granted and keeps the bus.
// R14: cpu lowest; transfer at cycle boundaries, never inside a split access.
// R15: a sleeping cpu hands the bus over immediately.
// R16: transfer controller raises its bus request on every activation request.
// R17: transfer controller yields only after a whole operation completes.
// R18: release waits for the running cycle to finish; read strobe stays low till then.
// R19: module-stop all-stopped or alternative with sleep disables bus release.
// R20: reset enters the reset state at once, aborting any running cycle.
// R21: each area select is low only during an access to that area.
// R22: without an enabled idle condition cycles follow back to back; here the next access waits in ST_IDLE for the request to drop.
`timescale 1ns/100ps
`default_nettype none
`include "ext_bus_regs.vh"
module ext_bus_idle_release_arbiter
#(
   parameter AREAS = 8,
   parameter AW    = 24,
   parameter DW    = 16
)
(
   // clock and reset
   input  wire              ref_clk_i,
   input  wire              reset_n_i,
   // configuration
   input  wire              idle_diff_area_read_en_i,
   input  wire              idle_write_after_read_en_i,
   input  wire              idle_cfg_load_i,
   input  wire              bus_release_enable_i,
   input  wire              release_drop_request_out_en_i,
   input  wire              expanded_mode_i,
   input  wire [15:0]       module_stop_reg_i,
   input  wire              cpu_sleep_i,
   // internal masters
   input  wire              cpu_req_i,
   input  wire              cpu_ext_i,
   input  wire              cpu_write_i,
   input  wire              cpu_locked_i,
   input  wire [2:0]        cpu_area_i,
   input  wire [AW-1:0]     cpu_addr_i,
   input  wire [DW-1:0]     cpu_wdata_i,
   input  wire              xfer_activate_i,
   input  wire              xfer_done_i,
   input  wire              xfer_op_busy_i,
   input  wire              xfer_ext_i,
   input  wire              xfer_write_i,
   input  wire [2:0]        xfer_area_i,
   input  wire [AW-1:0]     xfer_addr_i,
   input  wire [DW-1:0]     xfer_wdata_i,
   // external release link
   input  wire              ext_bus_request_n_i,
   output reg               bus_ack_n_o,
   output reg               drop_request_out_n_o,
   // external bus pins
   output reg  [AW-1:0]     addr_o,
   output reg               addr_oe_o,
   output reg  [DW-1:0]     data_o,
   output reg               data_oe_o,
   input  wire [DW-1:0]     data_i,
   output reg  [AREAS-1:0]  area_select_n_o,
   output reg               addr_strobe_n_o,
   output reg               read_strobe_n_o,
   output reg               upper_write_strobe_n_o,
   output reg               lower_write_strobe_n_o,
   output reg               ctrl_oe_o,
   // status
   output reg  [1:0]        owner_o,
   output reg               xfer_bus_req_o,
   output reg               ext_done_o,
   output reg  [DW-1:0]     rdata_o,
   output reg               idle_inserted_o,
   output reg               released_o
);
   // ===========================================
   // configuration and arbitration
   reg              idle_rr_en;
   reg              idle_wr_en;
   wire [1:0]       owner;
   reg  [2:0]       state;
   reg  [1:0]       cnt;
   reg              last_read;
   reg  [2:0]       last_area;
   reg              cur_write;
   reg  [2:0]       cur_area;
   reg  [DW-1:0]    cur_wdata;
   reg              ext_pend;
   wire             boundary;
   wire             sel_ext;
   wire             sel_write;
   wire [2:0]       sel_area;
   wire [AW-1:0]    sel_addr;
   wire [DW-1:0]    sel_wdata;
   wire             release_ok;
   wire             release_req;
   wire             need_idle;
   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         idle_rr_en <= `IDLE_EN_RESET; // R4
         idle_wr_en <= `IDLE_EN_RESET; // R4
      end
      else if (idle_cfg_load_i)
      begin
         idle_rr_en <= idle_diff_area_read_en_i;
         idle_wr_en <= idle_write_after_read_en_i;
      end
   end
   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         xfer_bus_req_o <= 1'b0;
      else if (xfer_activate_i)
         xfer_bus_req_o <= 1'b1; // R16
      else if (xfer_done_i)
         xfer_bus_req_o <= 1'b0;
   end
   assign boundary = (state != `ST_ACCESS) && (state != `ST_IDLE_INS);
   master_arbiter u_arb
   (
      .ref_clk_i        (ref_clk_i),
      .reset_n_i        (reset_n_i),
      .cpu_req_i        (cpu_req_i),
      .cpu_sleep_i      (cpu_sleep_i),
      .xfer_req_i       (xfer_bus_req_o),
      .xfer_op_busy_i   (xfer_op_busy_i),
      .cpu_locked_i     (cpu_locked_i),
      .cycle_boundary_i (boundary),
      .owner_o          (owner)
   );
   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         owner_o <= `MST_NONE;
      else
         owner_o <= owner; // R13
   end
   // ===========================================
   // selected master request
   assign sel_ext   = (owner == `MST_XFER) ? xfer_ext_i   : ((owner == `MST_CPU) ? (cpu_req_i && cpu_ext_i) : 1'b0);
   assign sel_write = (owner == `MST_XFER) ? xfer_write_i : cpu_write_i;
   assign sel_area  = (owner == `MST_XFER) ? xfer_area_i  : cpu_area_i;
   assign sel_addr  = (owner == `MST_XFER) ? xfer_addr_i  : cpu_addr_i;
   assign sel_wdata = (owner == `MST_XFER) ? xfer_wdata_i : cpu_wdata_i;
   // sleep with these module-stop codes kills the release clock path
   assign release_ok = expanded_mode_i && bus_release_enable_i // R6
                       && !(cpu_sleep_i && ((module_stop_reg_i == `MSTOP_ALL)
                       || (module_stop_reg_i == `MSTOP_ALT))); // R19
   assign release_req = release_ok && !ext_bus_request_n_i; // R7
   assign need_idle = last_read
                      && ((idle_rr_en && !sel_write && (sel_area != last_area)) // R1
                      || (idle_wr_en && sel_write)); // R2
   // ===========================================
   // bus state machine
   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state                  <= `ST_IDLE; // R20
         cnt                    <= 2'h0;
         last_read              <= 1'b0;
         last_area              <= 3'h0;
         cur_write              <= 1'b0;
         cur_area               <= 3'h0;
         cur_wdata              <= {DW{1'b0}};
         ext_pend               <= 1'b0;
         bus_ack_n_o            <= 1'b1;
         drop_request_out_n_o   <= 1'b1;
         addr_o                 <= {AW{1'b0}};
         addr_oe_o              <= 1'b1;
         data_o                 <= {DW{1'b0}};
         data_oe_o              <= 1'b0;
         area_select_n_o        <= {AREAS{1'b1}};
         addr_strobe_n_o        <= 1'b1;
         read_strobe_n_o        <= 1'b1;
         upper_write_strobe_n_o <= 1'b1;
         lower_write_strobe_n_o <= 1'b1;
         ctrl_oe_o              <= 1'b1;
         ext_done_o             <= 1'b0;
         rdata_o                <= {DW{1'b0}};
         idle_inserted_o        <= 1'b0;
         released_o             <= 1'b0;
      end
      else
      begin
         ext_done_o      <= 1'b0;
         idle_inserted_o <= 1'b0;
         case (state)
            `ST_IDLE:
            begin
               if (release_req) // R12 R18
               begin
                  state       <= `ST_RELEASED;
                  bus_ack_n_o <= 1'b0; // R8
                  addr_oe_o   <= 1'b0; // R8
                  data_oe_o   <= 1'b0;
                  ctrl_oe_o   <= 1'b0;
                  released_o  <= 1'b1;
               end
               else if (sel_ext && !ext_pend)
               begin
                  cur_write <= sel_write;
                  cur_area  <= sel_area;
                  cur_wdata <= sel_wdata;
                  addr_o    <= sel_addr; // R5
                  ext_pend  <= 1'b1;
                  if (need_idle)
                  begin
                     state           <= `ST_IDLE_INS; // R3
                     idle_inserted_o <= 1'b1;
                     data_oe_o       <= 1'b0; // R5
                  end
                  else
                  begin
                     state                  <= `ST_ACCESS; // R22
                     cnt                    <= `ACCESS_STATES - 2'h1;
                     area_select_n_o        <= ~({{(AREAS-1){1'b0}}, 1'b1} << sel_area); // R21
                     addr_strobe_n_o        <= 1'b0;
                     read_strobe_n_o        <= sel_write;
                     upper_write_strobe_n_o <= ~sel_write;
                     lower_write_strobe_n_o <= ~sel_write;
                     data_o                 <= sel_wdata;
                     data_oe_o              <= sel_write;
                  end
               end
               else if (!sel_ext)
                  ext_pend <= 1'b0;
            end
            `ST_IDLE_INS:
            begin
               // one state only, then the access proper begins
               state                  <= `ST_ACCESS; // R3
               cnt                    <= `ACCESS_STATES - 2'h1;
               area_select_n_o        <= ~({{(AREAS-1){1'b0}}, 1'b1} << cur_area); // R21
               addr_strobe_n_o        <= 1'b0;
               read_strobe_n_o        <= cur_write;
               upper_write_strobe_n_o <= ~cur_write;
               lower_write_strobe_n_o <= ~cur_write;
               data_o                 <= cur_wdata;
               data_oe_o              <= cur_write;
            end
            `ST_ACCESS:
            begin
               // the cycle always runs to its end; release waits for it
               if (cnt != 2'h0)
                  cnt <= cnt - 2'h1;
               else
               begin
                  ext_done_o             <= 1'b1;
                  last_read              <= !cur_write;
                  last_area              <= cur_area;
                  area_select_n_o        <= {AREAS{1'b1}};
                  addr_strobe_n_o        <= 1'b1;
                  upper_write_strobe_n_o <= 1'b1;
                  lower_write_strobe_n_o <= 1'b1;
                  data_oe_o              <= 1'b0;
                  if (!cur_write)
                     rdata_o <= data_i;
                  if (release_req)
                  begin
                     // read strobe floats from low without a high step
                     state       <= `ST_RELEASED; // R18
                     bus_ack_n_o <= 1'b0; // R8
                     addr_oe_o   <= 1'b0;
                     ctrl_oe_o   <= 1'b0;
                     released_o  <= 1'b1;
                  end
                  else
                  begin
                     state           <= `ST_IDLE;
                     read_strobe_n_o <= 1'b1;
                  end
               end
            end
            `ST_RELEASED:
            begin
               read_strobe_n_o      <= 1'b1;
               // external accesses wait here; internal work goes on
               drop_request_out_n_o <= ~(release_drop_request_out_en_i && sel_ext); // R9 R10
               if (ext_bus_request_n_i)
               begin
                  state                <= `ST_IDLE; // R11
                  bus_ack_n_o          <= 1'b1;
                  drop_request_out_n_o <= 1'b1;
                  addr_oe_o            <= 1'b1;
                  ctrl_oe_o            <= 1'b1;
                  released_o           <= 1'b0;
               end
            end
            default:
               state <= `ST_IDLE;
         endcase
      end
   end
endmodule // ext_bus_idle_release_arbiter
`default_nettype wire

//--- dv/ext_bus_chk_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// port checker for the bus controller
module ext_bus_chk
#(
   parameter AREAS = 8
)
(
   // watched ports
   input wire logic             ref_clk_i,
   input wire logic             reset_n_i,
   input wire logic             expanded_mode_i,
   input wire logic             bus_release_enable_i,
   input wire logic             release_drop_request_out_en_i,
   input wire logic             cpu_sleep_i,
   input wire logic [15:0]      module_stop_reg_i,
   input wire logic             xfer_activate_i,
   input wire logic             ext_bus_request_n_i,
   input wire logic             bus_ack_n_o,
   input wire logic             drop_request_out_n_o,
   input wire logic             addr_oe_o,
   input wire logic             data_oe_o,
   input wire logic             ctrl_oe_o,
   input wire logic [AREAS-1:0] area_select_n_o,
   input wire logic             addr_strobe_n_o,
   input wire logic             read_strobe_n_o,
   input wire logic             upper_write_strobe_n_o,
   input wire logic             lower_write_strobe_n_o,
   input wire logic             ext_done_o,
   input wire logic             idle_inserted_o,
   input wire logic             released_o,
   input wire logic             xfer_bus_req_o
);
   wire stop_bad = (module_stop_reg_i == 16'hFFFF) || (module_stop_reg_i == 16'hEFFF);
   wire quiet = (&area_select_n_o) & addr_strobe_n_o & read_strobe_n_o;
   wire wr_quiet = upper_write_strobe_n_o & lower_write_strobe_n_o;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   // a basic access: two states low, then strobes rise with done
   sequence s_strobe_low;
      !addr_strobe_n_o [*2];
   endsequence
   sequence s_cycle_end;
      addr_strobe_n_o && ext_done_o;
   endsequence
   a_idle_pins: assert property (idle_inserted_o |-> quiet && wr_quiet && !data_oe_o && addr_oe_o)
      else $error("idle state pins not at rest");
   a_idle_one: assert property (idle_inserted_o |=> !addr_strobe_n_o && !idle_inserted_o)
      else $error("idle state not one clock");
   a_access_len: assert property ($fell(addr_strobe_n_o) |-> s_strobe_low ##1 s_cycle_end)
      else $error("access length wrong");
   a_one_select: assert property (!addr_strobe_n_o |-> $countones(~area_select_n_o) == 1)
      else $error("area select not single");
   a_release_float: assert property (!bus_ack_n_o |-> !(addr_oe_o || data_oe_o || ctrl_oe_o))
      else $error("bus driven while released");
   a_release_gate: assert property ($fell(bus_ack_n_o) |-> $past(expanded_mode_i && bus_release_enable_i && !(cpu_sleep_i && stop_bad)))
      else $error("release granted while disabled");
   a_ack_return: assert property (released_o && ext_bus_request_n_i |=> bus_ack_n_o)
      else $error("ack stays low after request drop");
   a_hold_access: assert property (released_o && $past(released_o) |-> !ext_done_o)
      else $error("access done while released");
   a_drop_gate: assert property ($fell(drop_request_out_n_o) |-> $past(released_o && release_drop_request_out_en_i))
      else $error("drop request without cause");
   a_xfer_req: assert property (xfer_activate_i |=> xfer_bus_req_o)
      else $error("transfer request missing");
endmodule // ext_bus_chk
bind ext_bus_idle_release_arbiter ext_bus_chk #(.AREAS(AREAS)) u_chk (.*);
`default_nettype wire

//--- dv/ext_master.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// outside master sharing the external bus
module ext_master
(
   // clock, reset and bus side
   input  wire logic        ref_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        want_i,
   input  wire logic        read_strobe_n_i,
   input  wire logic        drop_request_n_i,
   output logic             ext_bus_request_n_o,
   output logic [15:0]      data_o
);
   logic yield;
   assign ext_bus_request_n_o = ~(want_i & ~yield);
   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         yield <= 1'b0;
         data_o <= 16'h0000;
      end
      else
      begin
         // gives way when asked, so a waiting access can run
         yield <= want_i & (yield | ~drop_request_n_i);
         // unread data lines flip every cycle so a stale value never passes
         data_o <= read_strobe_n_i ? ~data_o : 16'h5A3C;
      end
   end
endmodule // ext_master
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ext_bus_regs.vh"
// ==================================================
// bench: idle insertion, release and arbitration
module tb_top;
   logic        ref_clk_i = 1'b0, reset_n_i = 1'b0, want = 1'b0, idle_cfg_load_i = 1'b0;
   logic        idle_diff_area_read_en_i = 1'b1, idle_write_after_read_en_i = 1'b1;
   logic        bus_release_enable_i = 1'b0, release_drop_request_out_en_i = 1'b1, expanded_mode_i = 1'b1;
   logic        cpu_sleep_i = 1'b0, cpu_req_i = 1'b0, cpu_write_i = 1'b0;
   logic        xfer_activate_i = 1'b0, xfer_done_i = 1'b0;
   // tied: locked and busy cases are not exercised
   logic        cpu_ext_i = 1'b1, cpu_locked_i = 1'b0, xfer_op_busy_i = 1'b0, xfer_ext_i = 1'b0;
   logic [15:0] module_stop_reg_i = 16'h0000;
   logic [2:0]  cpu_area_i = 3'h0;
   logic [23:0] cpu_addr_i = 24'h000000;
   wire  [15:0] cpu_wdata_i = cpu_addr_i[15:0];
   wire  [15:0] xfer_wdata_i = ~cpu_wdata_i;
   wire  [23:0] xfer_addr_i = cpu_addr_i;
   wire  [2:0]  xfer_area_i = cpu_area_i;
   wire         xfer_write_i = cpu_write_i;
   logic        ext_bus_request_n_i, bus_ack_n_o, drop_request_out_n_o, addr_oe_o, data_oe_o, ctrl_oe_o;
   logic        addr_strobe_n_o, read_strobe_n_o, upper_write_strobe_n_o, lower_write_strobe_n_o;
   logic        xfer_bus_req_o, ext_done_o, idle_inserted_o, released_o;
   logic [23:0] addr_o;
   logic [15:0] data_o, data_i, rdata_o;
   logic [7:0]  area_select_n_o;
   logic [1:0]  owner_o;
   int          n_errors = 0, n_compared = 0, cyc = 0, n;
   ext_bus_idle_release_arbiter uut (.*);
   ext_master partner (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .want_i(want), .read_strobe_n_i(read_strobe_n_o),
      .drop_request_n_i(drop_request_out_n_o), .ext_bus_request_n_o(ext_bus_request_n_i), .data_o(data_i));
   initial
   begin
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         end_of_test();
      end
   end
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("mismatches %0d, comparisons %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // one cpu access; outputs are read at the falling edge, once settled
   task automatic acc(input logic wr, input logic [2:0] ar, input logic exp_idle);
      logic seen;
      seen = 1'b0;
      @(posedge ref_clk_i);
      cpu_req_i <= 1'b1;
      cpu_write_i <= wr;
      cpu_area_i <= ar;
      cpu_addr_i <= {ar, 21'h000ABC};
      for (int i = 0; i < 60 && ext_done_o !== 1'b1; i++)
      begin
         @(negedge ref_clk_i);
         seen = seen | (idle_inserted_o === 1'b1);
      end
      chk("access done", 1, ext_done_o);
      chk("idle state", exp_idle, seen);
      chk("address", {ar, 21'h000ABC}, addr_o);
      if (!wr)
         chk("read data", 24'h005A3C, rdata_o);
      @(posedge ref_clk_i);
      cpu_req_i <= 1'b0;
   endtask
   task automatic t_idle();
      acc(1'b0, 3'h1, 1'b0);
      acc(1'b0, 3'h2, 1'b1);
      acc(1'b0, 3'h2, 1'b0);
      acc(1'b1, 3'h2, 1'b1);
      acc(1'b1, 3'h3, 1'b0);
      @(posedge ref_clk_i);
      {idle_diff_area_read_en_i, idle_write_after_read_en_i, idle_cfg_load_i} <= 3'h1;
      @(posedge ref_clk_i);
      idle_cfg_load_i <= 1'b0;
      acc(1'b0, 3'h4, 1'b0);
      acc(1'b0, 3'h5, 1'b0);
      acc(1'b1, 3'h5, 1'b0);
   endtask
   // release, expanded mode, sleep and module stop combinations that refuse release
   task automatic t_ignored();
      logic [18:0] cases [4] = '{19'h20000, 19'h40000, 19'h7FFFF, 19'h7EFFF};
      for (int i = 0; i < 4; i++)
      begin
         @(posedge ref_clk_i);
         {bus_release_enable_i, expanded_mode_i, cpu_sleep_i, module_stop_reg_i} <= cases[i];
         want <= 1'b1;
         repeat (6) @(negedge ref_clk_i);
         chk("ignored release", 1, bus_ack_n_o);
         @(posedge ref_clk_i);
         want <= 1'b0;
      end
   endtask
   // release and a cpu access raised together; the access waits for the bus
   task automatic t_release();
      @(posedge ref_clk_i);
      {bus_release_enable_i, expanded_mode_i, cpu_sleep_i, module_stop_reg_i} <= 19'h60000;
      fork
         acc(1'b0, 3'h3, 1'b0);
         begin
            @(posedge ref_clk_i);
            want <= 1'b1;
            for (n = 0; n < 20 && bus_ack_n_o !== 1'b0; n++) @(negedge ref_clk_i);
            chk("strobe at release", 1, addr_strobe_n_o);
            chk("address drive", 0, addr_oe_o);
            for (n = 0; n < 20 && drop_request_out_n_o !== 1'b0; n++) @(negedge ref_clk_i);
            chk("drop request", 0, drop_request_out_n_o);
            chk("held access", 0, ext_done_o);
            for (n = 0; n < 20 && bus_ack_n_o !== 1'b1; n++) @(negedge ref_clk_i);
            chk("ack returned", 1, bus_ack_n_o);
            @(posedge ref_clk_i);
            want <= 1'b0;
         end
      join
   endtask
   task automatic t_arb();
      @(posedge ref_clk_i);
      {cpu_req_i, xfer_activate_i} <= 2'h3;
      @(posedge ref_clk_i);
      xfer_activate_i <= 1'b0;
      for (n = 0; n < 40 && owner_o !== `MST_XFER; n++) @(negedge ref_clk_i);
      chk("transfer request", 1, xfer_bus_req_o);
      chk("owner", `MST_XFER, owner_o);
      @(posedge ref_clk_i);
      xfer_done_i <= 1'b1;
      @(posedge ref_clk_i);
      xfer_done_i <= 1'b0;
      for (n = 0; n < 40 && owner_o !== `MST_CPU; n++) @(negedge ref_clk_i);
      chk("owner", `MST_CPU, owner_o);
      @(posedge ref_clk_i);
      cpu_req_i <= 1'b0;
   endtask
   initial
   begin
      repeat (4) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      t_idle();
      t_ignored();
      t_release();
      t_arb();
      repeat (8) @(posedge ref_clk_i);
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
